// [src/ipc_consts.svh]
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH
`define IPC_ADDR_PIN_CFG    8'h23
`define IPC_ADDR_IND_CFG    8'h24
`define IPC_ADDR_MASK       8'h25
`define IPC_ADDR_DET_FIRST  8'h26
`define IPC_ADDR_DET_SECOND 8'h27
`define IPC_RST_PIN_CFG     8'h21
`define IPC_RST_IND_CFG     8'h00
`define IPC_RST_MASK        8'h00
`define IPC_DRV_MSB         7
`define IPC_DRV_LSB         5
`define IPC_GPO_BIT         4
`define IPC_FUN_MSB         2
`define IPC_FUN_LSB         0
`define IPC_IND_MSB         7
`define IPC_IND_LSB         6
`define IPC_CLK_HZ          20000000
`define IPC_PULSE_US        2000
`define IPC_PERIOD_US       4000
`define IPC_PULSE_CYC       ((`IPC_CLK_HZ / 1000000) * `IPC_PULSE_US)
`define IPC_PERIOD_CYC      ((`IPC_CLK_HZ / 1000000) * `IPC_PERIOD_US)
`endif

// [src/ipc_pkg.sv]
package ipc_pkg;
  typedef enum logic [2:0] {
    IPC_FUN_OFF  = 3'h0,
    IPC_FUN_IRQ  = 3'h1,
    IPC_FUN_GPO  = 3'h3,
    IPC_FUN_PDM  = 3'h4
  } ipc_fun_t;
  typedef enum logic [2:0] {
    IPC_DRV_PUSHPULL = 3'h0,
    IPC_DRV_OD_LOW   = 3'h1,
    IPC_DRV_OD_HIGH  = 3'h2,
    IPC_DRV_PU_LOW   = 3'h3,
    IPC_DRV_PD_HIGH  = 3'h4
  } ipc_drv_t;
  typedef enum logic [1:0] {
    IPC_IND_ONE    = 2'h0,
    IPC_IND_REPEAT = 2'h1,
    IPC_IND_LEVEL  = 2'h2
  } ipc_ind_t;
  typedef enum logic [1:0] {
    IPC_ST_IDLE  = 2'b00,
    IPC_ST_HIGH  = 2'b01,
    IPC_ST_LOW   = 2'b11
  } ipc_st_t;
endpackage

// [src/ipc_sync.sv]
`timescale 1ns/1ps
module ipc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  if (W < 1) begin : gen_bad_width
    $error("ipc_sync: width must be positive");
  end

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Change accepted once stages two and three agree
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// [src/ipc_top.sv]
// What this block does
// [RULE1] Drive field bits 7:5 resets to 1; code 0 drives both levels
// [RULE2] Code 1 drives low, floats high; code 2 floats low, drives high
// [RULE3] Code 3 drives low with pull-up; code 4 pull-down, drives high
// [RULE4] Function field bits 2:0 resets to 1; code 0 disables pin buffers
// [RULE5] Function 1 puts masked interrupt indication on the pin
// [RULE6] Function 3 makes the pin a software-set output
// [RULE7] Function 4 outputs the divided PDM input clock
// [RULE8] Bit 4, reset 0, sets pin level in output mode
// [RULE9] Indication style bits 7:6 of second config register, reset 0
// [RULE10] Style 0 gives one 2ms high pulse per interrupt
// [RULE11] Style 1 repeats 2ms pulses every 4ms until flags cleared
// [RULE12] Style 2 holds pin high until flags cleared
// [RULE13] Mask bit 7 enables over-current interrupt
// [RULE14] Mask bit 6 enables analog under-voltage interrupt
// [RULE15] Mask bit 5 enables second clock-error interrupt
// [RULE16] Mask bit 4 enables over-temperature interrupt
// [RULE17] Mask bit 3 enables brownout interrupt
// [RULE18] Mask bit 2 enables first clock-error interrupt
// [RULE19] Mask bit 1 enables modulator clock halt interrupt
// [RULE20] Mask bit 0 enables word-clock halt interrupt
// [RULE21] First detection register is sticky and clears on read
// [RULE22] Clock halt events are sticky in the second detection register
// [RULE23] Interrupt when a flag newly sets while its mask bit is 1
// [RULE24] Pulse timing counter restarts at each new interrupt
`timescale 1ns/1ps
`include "ipc_consts.svh"
module ipc_top #(
  parameter int PULSE_CYC  = `IPC_PULSE_CYC,
  parameter int PERIOD_CYC = `IPC_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Event sources, pulses or levels
  input  wire logic       ev_overcurrent_i,
  input  wire logic       ev_analog_undervoltage_i,
  input  wire logic       ev_clock_error_a_i,
  input  wire logic       ev_overtemperature_i,
  input  wire logic       ev_brownout_i,
  input  wire logic       ev_clock_error_b_i,
  input  wire logic       ev_sar_done_i,
  input  wire logic       ev_word_clock_halt_i,
  input  wire logic       ev_modulator_clock_halt_i,
  // Divided PDM clock
  input  wire logic       pdm_input_divided_clock_i,
  // Alert pin
  output logic            alert_pin_o,
  output logic            alert_pin_oe_n_o,
  output logic            alert_pull_up_o,
  output logic            alert_pull_down_o,
  output logic            alert_buf_en_o
);
  // Pulse must fit inside its period; counter compares are 32 bits wide
  if (PULSE_CYC < 1 || PERIOD_CYC <= PULSE_CYC) begin : gen_bad_timing
    $error("ipc_top: bad pulse timing");
  end

  logic [7:0] pin_cfg_q;
  logic [7:0] ind_cfg_q;
  logic [7:0] mask_q;
  logic [7:0] det1_q;
  logic [7:0] det2_q;
  logic       pdm_clk_s;

  // Pin-sourced clock passes the three-stage filter
  ipc_sync #(.W(1)) u_pdm_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (pdm_input_divided_clock_i),
    .q_o       (pdm_clk_s)
  );

  logic [2:0] fun;
  logic [2:0] drv;
  logic [1:0] ind;
  assign fun = pin_cfg_q[`IPC_FUN_MSB:`IPC_FUN_LSB];
  assign drv = pin_cfg_q[`IPC_DRV_MSB:`IPC_DRV_LSB];
  assign ind = ind_cfg_q[`IPC_IND_MSB:`IPC_IND_LSB];

  // Configuration registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_cfg_q <= `IPC_RST_PIN_CFG; // RULE1 RULE4 RULE8
      ind_cfg_q <= `IPC_RST_IND_CFG; // RULE9
      mask_q    <= `IPC_RST_MASK;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `IPC_ADDR_PIN_CFG) begin
        pin_cfg_q <= reg_wdata_i;
      end else if (reg_addr_i == `IPC_ADDR_IND_CFG) begin
        ind_cfg_q <= reg_wdata_i;
      end else if (reg_addr_i == `IPC_ADDR_MASK) begin
        mask_q <= reg_wdata_i;
      end
    end
  end

  logic rd_det1;
  logic rd_det2;
  assign rd_det1 = reg_rd_i && (reg_addr_i == `IPC_ADDR_DET_FIRST);
  assign rd_det2 = reg_rd_i && (reg_addr_i == `IPC_ADDR_DET_SECOND);

  logic [7:0] ev1;
  logic [7:0] ev2;
  assign ev1 = {ev_overcurrent_i, ev_analog_undervoltage_i, ev_clock_error_a_i,
                ev_overtemperature_i, ev_brownout_i, ev_clock_error_b_i,
                ev_sar_done_i, 1'b0};
  assign ev2 = {ev_word_clock_halt_i, ev_modulator_clock_halt_i, 6'h00};

  // Sticky flags; a new event in the read cycle survives the clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      det1_q <= 8'h00;
      det2_q <= 8'h00;
    end else begin
      det1_q <= (rd_det1 ? 8'h00 : det1_q) | ev1; // RULE21
      det2_q <= (rd_det2 ? 8'h00 : det2_q) | ev2; // RULE22
    end
  end

  AST_DET1_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE21
    (rd_det1 && ev1 == 8'h00) |=> (det1_q == 8'h00))
    else $error("first detection byte not cleared by read");
  AST_DET2_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE22
    (det2_q[6] && !rd_det2) |=> det2_q[6])
    else $error("modulator halt flag lost without read");

  // Read data is registered
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `IPC_ADDR_PIN_CFG) begin
        reg_rdata_o <= pin_cfg_q;
      end else if (reg_addr_i == `IPC_ADDR_IND_CFG) begin
        reg_rdata_o <= ind_cfg_q;
      end else if (reg_addr_i == `IPC_ADDR_MASK) begin
        reg_rdata_o <= mask_q;
      end else if (rd_det1) begin
        reg_rdata_o <= det1_q;
      end else if (rd_det2) begin
        reg_rdata_o <= det2_q;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // Mask bits map to flags with differing positions in the two sticky bytes
  logic [7:0] act;
  assign act[7] = mask_q[7] & det1_q[7]; // RULE13
  assign act[6] = mask_q[6] & det1_q[6]; // RULE14
  assign act[5] = mask_q[5] & det1_q[2]; // RULE15
  assign act[4] = mask_q[4] & det1_q[4]; // RULE16
  assign act[3] = mask_q[3] & det1_q[3]; // RULE17
  assign act[2] = mask_q[2] & det1_q[5]; // RULE18
  assign act[1] = mask_q[1] & det2_q[6]; // RULE19
  assign act[0] = mask_q[0] & det2_q[7]; // RULE20

  logic [7:0] act_q;
  logic       new_irq;
  logic       any_act;
  assign new_irq = |(act & ~act_q); // RULE23
  assign any_act = |act;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q <= 8'h00;
    end else begin
      act_q <= act;
    end
  end

  ipc_pkg::ipc_st_t st_q;
  logic [31:0]      cnt_q;

  // Indication sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= ipc_pkg::IPC_ST_IDLE;
      cnt_q <= 32'h0;
    end else if (new_irq) begin
      st_q  <= ipc_pkg::IPC_ST_HIGH; // RULE24
      cnt_q <= 32'h0;
    end else begin
      case (st_q)
        ipc_pkg::IPC_ST_IDLE: begin
          cnt_q <= 32'h0;
        end
        ipc_pkg::IPC_ST_HIGH: begin
          if (ind == ipc_pkg::IPC_IND_LEVEL) begin
            cnt_q <= 32'h0;
            if (!any_act) begin
              st_q <= ipc_pkg::IPC_ST_IDLE; // RULE12
            end
          end else if (cnt_q == 32'(PULSE_CYC - 1)) begin
            cnt_q <= cnt_q + 32'h1;
            if (ind == ipc_pkg::IPC_IND_REPEAT) begin
              st_q <= ipc_pkg::IPC_ST_LOW; // RULE11
            end else begin
              st_q <= ipc_pkg::IPC_ST_IDLE; // RULE10
            end
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ipc_pkg::IPC_ST_LOW: begin
          if (cnt_q == 32'(PERIOD_CYC - 1)) begin
            cnt_q <= 32'h0;
            st_q  <= any_act ? ipc_pkg::IPC_ST_HIGH : ipc_pkg::IPC_ST_IDLE; // RULE11
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: begin
          st_q  <= ipc_pkg::IPC_ST_IDLE;
          cnt_q <= 32'h0;
        end
      endcase
    end
  end

  // Repeat style drops after the high phase and stops once no flag is left
  AST_REPEAT_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE11
    (st_q == ipc_pkg::IPC_ST_HIGH && ind == ipc_pkg::IPC_IND_REPEAT && !new_irq &&
     cnt_q == 32'(PULSE_CYC - 1))
      |=> (st_q == ipc_pkg::IPC_ST_LOW))
    else $error("repeat pulse did not go low");
  AST_REPEAT_STOP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE11
    (st_q == ipc_pkg::IPC_ST_LOW && !any_act && !new_irq &&
     cnt_q == 32'(PERIOD_CYC - 1))
      |=> (st_q == ipc_pkg::IPC_ST_IDLE))
    else $error("repeat pulses went on after flags cleared");

  logic irq_level;
  assign irq_level = (st_q == ipc_pkg::IPC_ST_HIGH);

  // Pin level source by function
  logic lvl_d;
  always_comb begin
    case (fun)
      ipc_pkg::IPC_FUN_IRQ: lvl_d = irq_level;             // RULE5
      ipc_pkg::IPC_FUN_GPO: lvl_d = pin_cfg_q[`IPC_GPO_BIT]; // RULE6 RULE8
      ipc_pkg::IPC_FUN_PDM: lvl_d = pdm_clk_s;             // RULE7
      default:              lvl_d = 1'b0;
    endcase
  end

  // Driver shaping; reserved codes and disabled pin leave the pin floating
  logic       en;
  logic [3:0] pad_d;
  assign en = (fun == ipc_pkg::IPC_FUN_IRQ) || (fun == ipc_pkg::IPC_FUN_GPO) ||
              (fun == ipc_pkg::IPC_FUN_PDM); // RULE4
  always_comb begin
    pad_d = {lvl_d, 1'b1, 1'b0, 1'b0};
    if (en) begin
      case (drv)
        ipc_pkg::IPC_DRV_PUSHPULL: pad_d = {lvl_d, 1'b0, 1'b0, 1'b0};  // RULE1
        ipc_pkg::IPC_DRV_OD_LOW:   pad_d = {1'b0, lvl_d, 1'b0, 1'b0};  // RULE2
        ipc_pkg::IPC_DRV_OD_HIGH:  pad_d = {1'b1, ~lvl_d, 1'b0, 1'b0}; // RULE2
        ipc_pkg::IPC_DRV_PU_LOW:   pad_d = {1'b0, lvl_d, 1'b1, 1'b0};  // RULE3
        ipc_pkg::IPC_DRV_PD_HIGH:  pad_d = {1'b1, ~lvl_d, 1'b0, 1'b1}; // RULE3
        default:                   pad_d = {1'b0, 1'b1, 1'b0, 1'b0};
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alert_pin_o       <= 1'b0;
      alert_pin_oe_n_o  <= 1'b1;
      alert_pull_up_o   <= 1'b0;
      alert_pull_down_o <= 1'b0;
      alert_buf_en_o    <= 1'b0;
    end else begin
      alert_pin_o       <= pad_d[3];
      alert_pin_oe_n_o  <= pad_d[2];
      alert_pull_up_o   <= pad_d[1];
      alert_pull_down_o <= pad_d[0];
      alert_buf_en_o    <= en;
    end
  end

  AST_DRV_PUSHPULL: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
    (en && drv == ipc_pkg::IPC_DRV_PUSHPULL)
      |=> (!alert_pin_oe_n_o && alert_pin_o == $past(lvl_d)))
    else $error("push-pull pin not driven to level");
  AST_DRV_OD_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
    (en && drv == ipc_pkg::IPC_DRV_OD_HIGH)
      |=> (alert_pin_o && alert_pin_oe_n_o != $past(lvl_d)))
    else $error("high-side open drain wrong");
  AST_DRV_PULL_UP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    (en && drv == ipc_pkg::IPC_DRV_PU_LOW)
      |=> (!alert_pin_o && alert_pin_oe_n_o == $past(lvl_d) &&
           alert_pull_up_o && !alert_pull_down_o))
    else $error("pull-up drive mode wrong");
  AST_DRV_PULL_DOWN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    (en && drv == ipc_pkg::IPC_DRV_PD_HIGH)
      |=> (alert_pin_o && alert_pin_oe_n_o != $past(lvl_d) &&
           alert_pull_down_o && !alert_pull_up_o))
    else $error("pull-down drive mode wrong");
  AST_DRV_RESERVED: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    (en && drv > 3'h4)
      |=> (alert_pin_oe_n_o && !alert_pull_up_o && !alert_pull_down_o))
    else $error("reserved drive code drives pin");
  AST_IRQ_PIN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE5
    (fun == ipc_pkg::IPC_FUN_IRQ && drv == ipc_pkg::IPC_DRV_OD_LOW)
      |=> (!alert_pin_o && alert_pin_oe_n_o == $past(irq_level)))
    else $error("indication not on pin");
  AST_PDM_PIN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
    (fun == ipc_pkg::IPC_FUN_PDM && drv == ipc_pkg::IPC_DRV_PUSHPULL)
      |=> (alert_pin_o == $past(pdm_clk_s)))
    else $error("divided clock not on pin");
  AST_STYLE0_WIDTH: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE10
    (irq_level && ind == ipc_pkg::IPC_IND_ONE && !new_irq && cnt_q == 32'(PULSE_CYC - 1))
      |=> !irq_level)
    else $error("single pulse too long");
  AST_MASK_GATES: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE23
    new_irq |-> (|(mask_q & {det1_q[7:6], det1_q[2], det1_q[4:3], det1_q[5],
                             det2_q[6], det2_q[7]})))
    else $error("interrupt without enabled flag");
  AST_NEW_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE24
    new_irq |=> (irq_level && cnt_q == 32'h0))
    else $error("new interrupt did not restart pulse");
  AST_LEVEL_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE12
    (irq_level && ind == ipc_pkg::IPC_IND_LEVEL && any_act && !new_irq) |=> irq_level)
    else $error("level indication dropped early");
  AST_STICKY: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE21
    (det1_q[7] && !rd_det1) |=> det1_q[7])
    else $error("sticky flag lost without read");
  AST_READ_CLR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE22
    (rd_det2 && !ev_word_clock_halt_i) |=> !det2_q[7])
    else $error("read did not clear flag");
  AST_GPO_PIN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
    (fun == ipc_pkg::IPC_FUN_GPO && drv == ipc_pkg::IPC_DRV_PUSHPULL)
      |=> (alert_pin_o == $past(pin_cfg_q[`IPC_GPO_BIT]) && !alert_pin_oe_n_o))
    else $error("manual level not on pin");
  AST_OFF_FLOAT: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
    (fun == ipc_pkg::IPC_FUN_OFF) |=> (alert_pin_oe_n_o && !alert_buf_en_o))
    else $error("disabled pin is driven");
  AST_OD_HIGHZ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
    (en && drv == ipc_pkg::IPC_DRV_OD_LOW && lvl_d) |=> alert_pin_oe_n_o)
    else $error("open drain drove high");
endmodule

// [sim/ipc_host_model.sv]
`timescale 1ns/1ps
module ipc_host_model (
  // Clock
  input  wire logic sys_clk_i,
  // Pin as the device presents it
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  input  wire logic pull_up_i,
  input  wire logic pull_down_i,
  // Level seen by the host
  output logic      level_o
);
  logic last_q = 1'b0;
  always_ff @(posedge sys_clk_i) begin
    if (!oe_n_i) begin
      last_q <= pin_i;
    end
  end
  // Undriven and unpulled: show the inverse so a stale value never passes
  always_comb begin
    if (!oe_n_i) begin
      level_o = pin_i;
    end else if (pull_up_i) begin
      level_o = 1'b1;
    end else if (pull_down_i) begin
      level_o = 1'b0;
    end else begin
      level_o = ~last_q;
    end
  end
endmodule

// [sim/ipc_top_bench.sv]
`timescale 1ns/1ps
module ipc_top_bench;
  // Short counts keep the run small
  localparam int PULSE_CYC  = 4;
  localparam int PERIOD_CYC = 8;
  logic       sys_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic [7:0] addr      = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic [7:0] wdata     = 8'h00;
  logic [8:0] ev        = 9'h000;
  logic       pdm       = 1'b0;
  logic [7:0] rdata;
  logic       pin, oe_n, pu, pd, buf_en, level;
  logic [7:0] d;
  int         err_total = 0;
  int         n_compared = 0;
  int         h, l;
  logic       ok;
  always #25 sys_clk_i = ~sys_clk_i;
  ipc_top #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) ipc_top_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .ev_overcurrent_i(ev[7]), .ev_analog_undervoltage_i(ev[6]),
    .ev_clock_error_a_i(ev[2]), .ev_overtemperature_i(ev[4]), .ev_brownout_i(ev[3]),
    .ev_clock_error_b_i(ev[5]), .ev_sar_done_i(ev[8]), .ev_word_clock_halt_i(ev[0]),
    .ev_modulator_clock_halt_i(ev[1]), .pdm_input_divided_clock_i(pdm),
    .alert_pin_o(pin), .alert_pin_oe_n_o(oe_n), .alert_pull_up_o(pu),
    .alert_pull_down_o(pd), .alert_buf_en_o(buf_en));
  ipc_host_model ipc_host_model_inst (
    .sys_clk_i(sys_clk_i), .pin_i(pin), .oe_n_i(oe_n), .pull_up_i(pu),
    .pull_down_i(pd), .level_o(level));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Counts: compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge sys_clk_i) wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i) begin addr <= a; rd <= 1'b1; end
    @(posedge sys_clk_i) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge sys_clk_i) ev <= m;
    @(posedge sys_clk_i) ev <= 9'h000;
    #1;
  endtask
  task automatic wait_rise(input int lim);
    ok = 1'b0;
    repeat (lim) begin
      cyc(1);
      if (level === 1'b1) begin ok = 1'b1; break; end
    end
  endtask
  // High run, then low run, each capped at 30 samples
  task automatic measure;
    h = 0; l = 0;
    while (level === 1'b1 && h < 30) begin h++; cyc(1); end
    while (level === 1'b0 && l < 30) begin l++; cyc(1); end
  endtask
  task automatic quiet(input int n);
    h = 0;
    repeat (n) begin cyc(1); if (level !== 1'b0) h++; end
  endtask
  task automatic t_reset;
    chk({5'h00, buf_en, oe_n, level}, 8'h04);
    rd_reg(8'h23, d); chk(d, 8'h21);
    rd_reg(8'h24, d); chk(d, 8'h00);
    rd_reg(8'h25, d); chk(d, 8'h00);
    rd_reg(8'h30, d); chk(d, 8'h00);
    wr_reg(8'h26, 8'hFF); rd_reg(8'h26, d); chk(d, 8'h00);
    wr_reg(8'h24, 8'hC0); rd_reg(8'h24, d); chk(d, 8'hC0);
    wr_reg(8'h24, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_masks;
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h25, 8'(1 << i));
      pulse(9'(1 << i));
      wait_rise(10); chk(8'(ok), 8'h01);
      measure; chk(8'(h), 8'(PULSE_CYC)); chk(8'(l), 8'd30);
      rd_reg(8'h26, d);
      chk(d, (i < 2) ? 8'h00 : (i == 5) ? 8'h04 : (i == 2) ? 8'h20 : 8'(1 << i));
      rd_reg(8'h27, d); chk(d, (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : 8'h00);
    end
    wr_reg(8'h25, 8'h00);
    pulse(9'h1FF); wait_rise(10); chk(8'(ok), 8'h00);
    rd_reg(8'h26, d); chk(d, 8'hFE);
    rd_reg(8'h27, d); chk(d, 8'hC0);
    rd_reg(8'h26, d); chk(d, 8'h00);
    wr_reg(8'h25, 8'hFF);
    pulse(9'h100); wait_rise(10); chk(8'(ok), 8'h00);
    rd_reg(8'h26, d); chk(d, 8'h02);
    $display("t_masks done");
  endtask
  task automatic t_styles;
    wr_reg(8'h24, 8'h40);
    pulse(9'h080); wait_rise(10); chk(8'(ok), 8'h01);
    measure; chk(8'(h), 8'(PULSE_CYC)); chk(8'(l), 8'(PERIOD_CYC - PULSE_CYC));
    measure; chk(8'(h), 8'(PULSE_CYC));
    rd_reg(8'h26, d); rd_reg(8'h27, d); cyc(8); quiet(20); chk(8'(h), 8'h00);
    wr_reg(8'h24, 8'h80);
    pulse(9'h001); wait_rise(10); chk(8'(ok), 8'h01);
    measure; chk(8'(h), 8'd30);
    rd_reg(8'h26, d); cyc(5); chk(8'(level), 8'h01);
    rd_reg(8'h27, d); cyc(4); quiet(20); chk(8'(h), 8'h00);
    wr_reg(8'h24, 8'h00);
    $display("t_styles done");
  endtask
  task automatic t_pin;
    // Codes 1 and 2 float one level with no pull, so level is only judged on 0, 3, 4
    for (int c = 0; c < 5; c++) begin
      for (int g = 0; g < 2; g++) begin
        wr_reg(8'h23, {3'(c), 1'(g), 4'h3}); cyc(3);
        chk(8'(oe_n), g ? 8'(c == 1 || c == 3) : 8'(c == 2 || c == 4));
        chk({6'h0, pu, pd}, {6'h0, 1'(c == 3), 1'(c == 4)});
        if (c == 0 || c > 2) chk(8'(level), 8'(g));
      end
    end
    wr_reg(8'h23, 8'h00); cyc(3); chk(8'(buf_en), 8'h00);
    wr_reg(8'h23, 8'h02); cyc(3); chk(8'(buf_en), 8'h00);
    wr_reg(8'h23, 8'hB3); cyc(3); chk(8'(oe_n), 8'h01);
    rd_reg(8'h23, d); chk(d, 8'hB3);
    wr_reg(8'h23, 8'h04);
    @(posedge sys_clk_i) pdm <= 1'b1;
    cyc(7); chk({6'h00, buf_en, level}, 8'h03);
    @(posedge sys_clk_i) pdm <= 1'b0;
    cyc(7); chk(8'(level), 8'h00);
    wr_reg(8'h23, 8'h21);
    $display("t_pin done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    cyc(2);
    t_reset;
    t_masks;
    t_styles;
    t_pin;
    end_of_test;
  end
  initial begin
    repeat (6000) @(posedge sys_clk_i);
    err_total++;
    $display("Watchdog expired at t=%0t", $time);
    end_of_test;
  end
endmodule
